// *** verilog/ucp_pkg.sv ***
/*
  Shared constants and types for the undercurrent protection step block.
  Assumes a 100 MHz system clock and word-addressed register access.
*/
`default_nettype none
package ucp_pkg;
  // ==========================================================================
  // Sizes
  localparam int UCP_SETS = 4;
  localparam int UCP_STEPS = 3;
  localparam int UCP_CFGS = UCP_SETS * UCP_STEPS;
  localparam int UCP_AW = 9;
  localparam int UCP_DW = 32;
  localparam int UCP_CUR_W = 16;
  localparam int UCP_EVT_W = 14;
  localparam int UCP_TIME_W = 30;

  // ==========================================================================
  // Timing: the delays count in whole milliseconds.
  localparam int UCP_CLK_PERIOD_NS = 10;
  localparam int UCP_TICK_NS = 1000000;
  localparam int UCP_TICK_CYC = UCP_TICK_NS / UCP_CLK_PERIOD_NS;

  // ==========================================================================
  // Address map (word addresses). Bit 8 selects the global page; otherwise
  // bits 7:6 pick the set, bits 5:4 the slot (0..2 step, 3 set-wide), 3:0 field.
  localparam logic [1:0] UCP_SLOT_SET = 2'h3;
  localparam logic [3:0] UCP_F_SEL = 4'h0;
  localparam logic [3:0] UCP_F_SBLK = 4'h1;
  localparam logic [3:0] UCP_F_PK = 4'h2;
  localparam logic [3:0] UCP_F_TDLY = 4'h3;
  localparam logic [3:0] UCP_F_REL = 4'h4;
  localparam logic [3:0] UCP_F_TRD = 4'h5;
  localparam logic [3:0] UCP_F_PRD = 4'h6;
  localparam logic [3:0] UCP_F_EN = 4'h0;
  localparam logic [3:0] UCP_F_MBLK = 4'h1;
  localparam logic [3:0] UCP_G_ACT_SET = 4'h0;
  localparam logic [3:0] UCP_G_FLAGS = 4'h1;
  localparam logic [3:0] UCP_G_INT_STAT = 4'h2;
  localparam logic [3:0] UCP_G_INT_EN = 4'h3;
  localparam logic [3:0] UCP_G_INT_CLR = 4'h4;

  // Flags word: bit0 module active, bit1 module blocked, then per step
  // four bits from UCP_FL_STEP0: active, blocked, pickup, trip.
  localparam int UCP_FL_STEP0 = 2;
  // Interrupt word: bit 2*n pickup rise of step n, bit 2*n+1 trip rise.
  localparam int UCP_INT_W = 2 * UCP_STEPS;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    UCP_SRC_NONE = 2'h0,
    UCP_SRC_ONE = 2'h1,
    UCP_SRC_TWO = 2'h2
  } ucp_src_e;

  // Three phase currents in 0.1 % of the nominal current.
  typedef struct packed {
    logic [UCP_CUR_W-1:0] ph_a;
    logic [UCP_CUR_W-1:0] ph_b;
    logic [UCP_CUR_W-1:0] ph_c;
  } ucp_cur3_s;

  typedef struct packed {
    ucp_src_e sel;
    logic [UCP_EVT_W-1:0] sblk;
    logic [UCP_CUR_W-1:0] pk;
    logic [UCP_TIME_W-1:0] tdly;
    logic [UCP_CUR_W-1:0] rel;
    logic [UCP_TIME_W-1:0] trd;
    logic [UCP_TIME_W-1:0] prd;
  } ucp_step_cfg_s;

  // ==========================================================================
  // Reset values: pickup 300.0 %, release 350.0 %, trip delay 1.0 s.
  localparam logic UCP_EN_RST = 1'b1;
  localparam logic [UCP_EVT_W-1:0] UCP_BLK_RST = 14'h0000;
  localparam logic [UCP_CUR_W-1:0] UCP_PK_RST = 16'h0bb8;
  localparam logic [UCP_CUR_W-1:0] UCP_REL_RST = 16'h0dac;
  localparam logic [UCP_TIME_W-1:0] UCP_TDLY_RST = 30'h000003e8;
  localparam logic [UCP_TIME_W-1:0] UCP_TRD_RST = 30'h00000000;
  localparam logic [UCP_TIME_W-1:0] UCP_PRD_RST = 30'h00000000;
  localparam logic [1:0] UCP_ACT_SET_RST = 2'h0;
endpackage : ucp_pkg
`default_nettype wire

// *** verilog/ucp_step_unit.sv ***
/*
  Undercurrent protection: four parameter sets of three definite-time steps,
  module enable and blocking, register port and one level interrupt.
  Assumes currents and event answers come from logic on clk_sys; blocking
  events are looked up one source per cycle through an event query port.
*/
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ucp_step_unit #(
  parameter int TICK_CYC = ucp_pkg::UCP_TICK_CYC  // Cycles per millisecond tick.
) (
  input wire logic clk_sys,  // System clock, 100 MHz.
  input wire logic arst_n,  // Asynchronous reset, active low.
  input wire logic [ucp_pkg::UCP_AW-1:0] reg_addr,  // Register word address.
  input wire logic [ucp_pkg::UCP_DW-1:0] reg_wdata,  // Write data.
  input wire logic reg_wr,  // Write strobe.
  input wire logic reg_rd,  // Read strobe.
  output logic [ucp_pkg::UCP_DW-1:0] reg_rdata,  // Read data, cycle after reg_rd.
  input wire ucp_pkg::ucp_cur3_s current_input_one,  // Phase currents, input one.
  input wire ucp_pkg::ucp_cur3_s current_input_two,  // Phase currents, input two.
  output logic [ucp_pkg::UCP_EVT_W-1:0] evt_query_num,  // Event number asked.
  input wire logic evt_query_active,  // Answer for the number of last cycle.
  output logic module_active_flag,  // Module enabled.
  output logic module_blocked_flag,  // Module blocked.
  output logic [ucp_pkg::UCP_STEPS-1:0] step_active_flag,  // Per step active.
  output logic [ucp_pkg::UCP_STEPS-1:0] step_blocked_flag,  // Per step blocked.
  output logic [ucp_pkg::UCP_STEPS-1:0] pickup_flag,  // Per step pickup.
  output logic [ucp_pkg::UCP_STEPS-1:0] trip_flag,  // Per step trip.
  output logic irq  // Level interrupt.
);
  import ucp_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [3:0] cfg_idx(input logic [1:0] set, input logic [1:0] step);
    cfg_idx = 4'(set * 3 + step);
  endfunction : cfg_idx

  function automatic logic any_below(input ucp_cur3_s c, input logic [UCP_CUR_W-1:0] thr);
    any_below = (c.ph_a < thr) || (c.ph_b < thr) || (c.ph_c < thr);
  endfunction : any_below

  function automatic logic all_above(input ucp_cur3_s c, input logic [UCP_CUR_W-1:0] thr);
    all_above = (c.ph_a > thr) && (c.ph_b > thr) && (c.ph_c > thr);
  endfunction : all_above

  // ==========================================================================
  // Register storage
  logic [1:0] act_set;
  logic set_en [UCP_SETS];
  logic [UCP_EVT_W-1:0] set_mblk [UCP_SETS];
  ucp_step_cfg_s cfg [UCP_CFGS];
  logic [UCP_INT_W-1:0] int_stat;
  logic [UCP_INT_W-1:0] int_en;
  logic [UCP_INT_W-1:0] int_evt;

  wire logic is_glb = reg_addr[8];
  wire logic [1:0] a_set = reg_addr[7:6];
  wire logic [1:0] a_slot = reg_addr[5:4];
  wire logic [3:0] a_fld = reg_addr[3:0];
  wire logic [3:0] a_idx = cfg_idx(a_set, a_slot);

  // Set-wide settings and step settings of all four sets.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < UCP_SETS; s++) begin
        set_en[s] <= UCP_EN_RST;
        set_mblk[s] <= UCP_BLK_RST;
      end
      for (int i = 0; i < UCP_CFGS; i++) begin
        cfg[i] <= '{sel: UCP_SRC_ONE, sblk: UCP_BLK_RST, pk: UCP_PK_RST, tdly: UCP_TDLY_RST,
                    rel: UCP_REL_RST, trd: UCP_TRD_RST, prd: UCP_PRD_RST};
      end
    end else if (reg_wr && !is_glb) begin
      if (a_slot == UCP_SLOT_SET) begin
        case (a_fld)
          UCP_F_EN: set_en[a_set] <= reg_wdata[0];
          UCP_F_MBLK: set_mblk[a_set] <= reg_wdata[UCP_EVT_W-1:0];
          default: ;
        endcase
      end else begin
        case (a_fld)
          UCP_F_SEL: cfg[a_idx].sel <= ucp_src_e'(reg_wdata[1:0]);
          UCP_F_SBLK: cfg[a_idx].sblk <= reg_wdata[UCP_EVT_W-1:0];
          UCP_F_PK: cfg[a_idx].pk <= reg_wdata[UCP_CUR_W-1:0];
          UCP_F_TDLY: cfg[a_idx].tdly <= reg_wdata[UCP_TIME_W-1:0];
          UCP_F_REL: cfg[a_idx].rel <= reg_wdata[UCP_CUR_W-1:0];
          UCP_F_TRD: cfg[a_idx].trd <= reg_wdata[UCP_TIME_W-1:0];
          UCP_F_PRD: cfg[a_idx].prd <= reg_wdata[UCP_TIME_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Active set and interrupt enable.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      act_set <= UCP_ACT_SET_RST;
      int_en <= '0;
    end else if (reg_wr && is_glb) begin
      if (a_fld == UCP_G_ACT_SET) begin
        act_set <= reg_wdata[1:0];
      end
      if (a_fld == UCP_G_INT_EN) begin
        int_en <= reg_wdata[UCP_INT_W-1:0];
      end
    end
  end

  // Sticky status: a new event in the clearing cycle survives the clear.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~((reg_wr && is_glb && a_fld == UCP_G_INT_CLR) ?
                   reg_wdata[UCP_INT_W-1:0] : '0)) | int_evt;
    end
  end

  assign irq = |(int_stat & int_en);

  // ==========================================================================
  // Read path. Unmapped words read zero; the clear word is write-only.
  logic [UCP_DW-1:0] rd_mux;
  logic [UCP_DW-1:0] flags_word;

  always_comb begin
    flags_word = '0;
    flags_word[0] = module_active_flag;
    flags_word[1] = module_blocked_flag;
    for (int g = 0; g < UCP_STEPS; g++) begin
      flags_word[UCP_FL_STEP0 + 4*g] = step_active_flag[g];
      flags_word[UCP_FL_STEP0 + 4*g + 1] = step_blocked_flag[g];
      flags_word[UCP_FL_STEP0 + 4*g + 2] = pickup_flag[g];
      flags_word[UCP_FL_STEP0 + 4*g + 3] = trip_flag[g];
    end
  end

  always_comb begin
    rd_mux = '0;
    if (is_glb) begin
      case (a_fld)
        UCP_G_ACT_SET: rd_mux[1:0] = act_set;
        UCP_G_FLAGS: rd_mux = flags_word;
        UCP_G_INT_STAT: rd_mux[UCP_INT_W-1:0] = int_stat;
        UCP_G_INT_EN: rd_mux[UCP_INT_W-1:0] = int_en;
        default: rd_mux = '0;
      endcase
    end else if (a_slot == UCP_SLOT_SET) begin
      case (a_fld)
        UCP_F_EN: rd_mux[0] = set_en[a_set];
        UCP_F_MBLK: rd_mux[UCP_EVT_W-1:0] = set_mblk[a_set];
        default: rd_mux = '0;
      endcase
    end else begin
      case (a_fld)
        UCP_F_SEL: rd_mux[1:0] = cfg[a_idx].sel;
        UCP_F_SBLK: rd_mux[UCP_EVT_W-1:0] = cfg[a_idx].sblk;
        UCP_F_PK: rd_mux[UCP_CUR_W-1:0] = cfg[a_idx].pk;
        UCP_F_TDLY: rd_mux[UCP_TIME_W-1:0] = cfg[a_idx].tdly;
        UCP_F_REL: rd_mux[UCP_CUR_W-1:0] = cfg[a_idx].rel;
        UCP_F_TRD: rd_mux[UCP_TIME_W-1:0] = cfg[a_idx].trd;
        UCP_F_PRD: rd_mux[UCP_TIME_W-1:0] = cfg[a_idx].prd;
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ==========================================================================
  // Millisecond tick for all delay timers.
  logic [$clog2(TICK_CYC+1)-1:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == ($bits(tick_cnt))'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Blocking lookup: slot 0 is the module source, slots 1..3 the steps. One
  // slot per cycle; the answer comes a cycle after the number, so the slot
  // and its zero test ride one more stage to pair with it.
  logic [1:0] q_slot;
  logic [1:0] q_prev;
  logic q_nz;
  logic [1:0] q_ans_slot;
  logic q_ans_nz;
  logic [UCP_STEPS:0] blk_state;
  logic [UCP_EVT_W-1:0] next_query;

  always_comb begin
    if (q_slot == 2'h0) begin
      next_query = set_mblk[act_set];
    end else begin
      next_query = cfg[cfg_idx(act_set, q_slot - 2'h1)].sblk;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_slot <= 2'h0;
      q_prev <= 2'h0;
      q_nz <= 1'b0;
      q_ans_slot <= 2'h0;
      q_ans_nz <= 1'b0;
      evt_query_num <= '0;
      blk_state <= '0;
    end else begin
      q_slot <= q_slot + 2'h1;
      q_prev <= q_slot;
      evt_query_num <= next_query;
      q_nz <= (next_query != '0);
      q_ans_slot <= q_prev;
      q_ans_nz <= q_nz;
      blk_state[q_ans_slot] <= q_ans_nz && evt_query_active;
    end
  end

  assign module_active_flag = set_en[act_set];
  assign module_blocked_flag = blk_state[0];

  // ==========================================================================
  // Steps of the active set.
  logic [UCP_STEPS-1:0] pk_prev;
  logic [UCP_STEPS-1:0] tr_prev;

  generate
    for (genvar g = 0; g < UCP_STEPS; g++) begin : g_step
      ucp_step_cfg_s c;
      logic run;
      logic below;
      logic above_both;
      logic above_rel;
      logic pk;
      logic tr;
      logic [UCP_TIME_W-1:0] tacc;
      logic [UCP_TIME_W-1:0] trc;
      logic [UCP_TIME_W-1:0] prc;

      assign c = cfg[cfg_idx(act_set, 2'(g))];
      assign step_active_flag[g] = (c.sel == UCP_SRC_ONE);
      assign step_blocked_flag[g] = blk_state[g+1];
      // Input two does not exist on this variant, so it never runs.
      assign run = module_active_flag && !module_blocked_flag
                   && !step_blocked_flag[g] && step_active_flag[g];
      // Thresholds in tenths of a percent of nominal.
      assign below = any_below(current_input_one, c.pk);
      assign above_both = all_above(current_input_one, c.pk) && all_above(current_input_one, c.rel);
      assign above_rel = all_above(current_input_one, c.rel);

      // Pickup and trip flags.
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          pk <= 1'b0;
          tr <= 1'b0;
        end else if (!run) begin
          pk <= 1'b0;
          tr <= 1'b0;
        end else begin
          if (below) begin
            pk <= 1'b1;
          end else if (pk && above_both) begin
            pk <= 1'b0;
          end
          if (pk && tacc >= c.tdly) begin
            tr <= 1'b1;
          end
          // Release wins over a set in the same cycle so a zero delay can end trip.
          if (tr && above_rel && trc >= c.trd) begin
            tr <= 1'b0;
          end
        end
      end

      // Trip delay accumulator: runs while below, clears once pickup is off and prc reaches prd, holds otherwise.
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          tacc <= '0;
        end else if (!run) begin
          tacc <= '0;
        end else if (below) begin
          if (tick && tacc < c.tdly) begin
            tacc <= tacc + 1'b1;
          end
        end else if (!pk && prc >= c.prd) begin
          tacc <= '0;
        end
        // Otherwise the count is held.
      end

      // Pickup release timer runs only while pickup is off.
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          prc <= '0;
        end else if (!run || pk || below) begin
          prc <= '0;
        end else if (tick && prc < c.prd) begin
          prc <= prc + 1'b1;
        end
      end

      // Trip release timer; a new under-run restarts it.
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          trc <= '0;
        end else if (!run || !tr || below || !above_rel) begin
          trc <= '0;
        end else if (tick && trc < c.trd) begin
          trc <= trc + 1'b1;
        end
      end

      assign pickup_flag[g] = pk;
      assign trip_flag[g] = tr;
      assign int_evt[2*g] = pk && !pk_prev[g];
      assign int_evt[2*g+1] = tr && !tr_prev[g];
    end
  endgenerate

  // Previous flag copies for the interrupt edge detectors.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pk_prev <= '0;
      tr_prev <= '0;
    end else begin
      pk_prev <= pickup_flag;
      tr_prev <= trip_flag;
    end
  end
endmodule : ucp_step_unit
`default_nettype wire

// *** tb/ucp_evt_model.sv ***
/*
  Event system model that answers the unit's blocking queries.
  Assumes one active event number set by the bench, on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ucp_evt_model (
  input wire logic clk_sys, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [ucp_pkg::UCP_EVT_W-1:0] evt_query_num, // Number asked.
  input wire logic [ucp_pkg::UCP_EVT_W-1:0] ev_on, // Event active now.
  output logic evt_query_active // Answer one cycle later.
);
  import ucp_pkg::*;
  // ==========================================================================
  // Answer
  // Number zero is reported active on purpose, so a unit that fails to
  // ignore an unset source is caught rather than helped.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      evt_query_active <= 1'b0;
    end else begin
      evt_query_active <= (evt_query_num == ev_on) || (evt_query_num == '0);
    end
  end
endmodule : ucp_evt_model
`default_nettype wire

// *** tb/ucp_step_checker.sv ***
/*
  Concurrent checks on the ports of the undercurrent protection unit.
  Assumes one clock domain and the bind below, at every unit instance.
*/
`timescale 1ns/1ns
`default_nettype none
module ucp_step_checker #(
  parameter int TICK_CYC = 4 // Cycles per tick, as in the unit.
) (
  input wire logic clk_sys, // System clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic [ucp_pkg::UCP_AW-1:0] reg_addr, // Address.
  input wire logic [ucp_pkg::UCP_DW-1:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [ucp_pkg::UCP_DW-1:0] reg_rdata, // Read data.
  input wire ucp_pkg::ucp_cur3_s current_input_one, // Input one.
  input wire ucp_pkg::ucp_cur3_s current_input_two, // Input two.
  input wire logic [ucp_pkg::UCP_EVT_W-1:0] evt_query_num, // Query.
  input wire logic evt_query_active, // Answer.
  input wire logic module_active_flag, // Module active.
  input wire logic module_blocked_flag, // Module blocked.
  input wire logic [ucp_pkg::UCP_STEPS-1:0] step_active_flag, // Active.
  input wire logic [ucp_pkg::UCP_STEPS-1:0] step_blocked_flag, // Blocked.
  input wire logic [ucp_pkg::UCP_STEPS-1:0] pickup_flag, // Pickup.
  input wire logic [ucp_pkg::UCP_STEPS-1:0] trip_flag, // Trip.
  input wire logic irq // Interrupt.
);
  import ucp_pkg::*;
  logic [13:0] flg_w;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Flags word as the register must show it.
  assign flg_w = {trip_flag[2], pickup_flag[2], step_blocked_flag[2], step_active_flag[2],
    trip_flag[1], pickup_flag[1], step_blocked_flag[1], step_active_flag[1],
    trip_flag[0], pickup_flag[0], step_blocked_flag[0], step_active_flag[0],
    module_blocked_flag, module_active_flag};

  // ==========================================================================
  // Register port
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  rdata_void_a: assert property ($past(reg_rd) && ($past(reg_addr) == 9'h1ff || $past(reg_addr) == 9'h104)
    |-> reg_rdata == '0) else $error("unmapped or clear word read not zero");
  flags_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 9'h101
    |-> reg_rdata == {18'h0, $past(flg_w)}) else $error("flags word differs from flag ports");

  // ==========================================================================
  // Blocking and gating
  mod_blk_rise_a: assert property ($rose(module_blocked_flag)
    |-> $past(evt_query_active) && $past(evt_query_num, 2) != '0) else $error("module blocked without cause");
  step_blk_rise_a: assert property ($rose(step_blocked_flag[1])
    |-> $past(evt_query_active) && $past(evt_query_num, 2) != '0) else $error("step blocked without cause");
  mod_off_a: assert property (!module_active_flag |=> (pickup_flag | trip_flag) == '0)
    else $error("flags active while module disabled");
  mod_blk_a: assert property (module_blocked_flag |=> (pickup_flag | trip_flag) == '0)
    else $error("flags active while module blocked");
  step_off_a: assert property (1'b1 |=>
    ((pickup_flag | trip_flag) & $past(step_blocked_flag | ~step_active_flag)) == '0)
    else $error("flags active on blocked or inactive step");
  trip_cause_a: assert property ($rose(trip_flag[0]) |-> $past(pickup_flag[0]))
    else $error("trip raised without pickup");
endmodule : ucp_step_checker

bind ucp_step_unit ucp_step_checker #(.TICK_CYC(TICK_CYC)) i_chk (.clk_sys, .arst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .current_input_one, .current_input_two, .evt_query_num,
  .evt_query_active, .module_active_flag, .module_blocked_flag, .step_active_flag, .step_blocked_flag,
  .pickup_flag, .trip_flag, .irq);
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the undercurrent protection unit with a flag model.
  Assumes the millisecond tick is shortened to a few cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ucp_pkg::*;
  localparam int TK = 4;
  localparam int TD = 8;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [UCP_AW-1:0] reg_addr = '0;
  logic [UCP_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [UCP_DW-1:0] reg_rdata;
  ucp_cur3_s current_input_one = '1;
  ucp_cur3_s current_input_two = '0;
  logic [UCP_EVT_W-1:0] evt_query_num;
  logic [UCP_EVT_W-1:0] ev_on = '0;
  logic evt_query_active;
  logic module_active_flag;
  logic module_blocked_flag;
  logic [2:0] step_active_flag;
  logic [2:0] step_blocked_flag;
  logic [2:0] pickup_flag;
  logic [2:0] trip_flag;
  logic irq;
  logic [31:0] pw;
  logic [31:0] d;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h4ac028b7;
  int n;
  // Model of the flags the unit should show.
  logic m_ma = 1'b1;
  logic m_mb = 1'b0;
  logic [2:0] m_a = 3'b111;
  logic [2:0] m_b = 3'b000;
  logic [2:0] m_p = 3'b000;
  logic [2:0] m_t = 3'b000;

  always #5 clk_sys = ~clk_sys;

  ucp_step_unit #(.TICK_CYC(TK)) i_dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .current_input_one, .current_input_two, .evt_query_num, .evt_query_active,
    .module_active_flag, .module_blocked_flag, .step_active_flag, .step_blocked_flag, .pickup_flag,
    .trip_flag, .irq);
  ucp_evt_model i_evt (.clk_sys, .arst_n, .evt_query_num, .ev_on, .evt_query_active);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] fw(logic ma, logic mb, logic [2:0] a, b, p, t);
    logic [31:0] w;
    w = {30'h0, mb, ma};
    for (int i = 0; i < 3; i++) w[2+4*i +: 4] = {t[i], p[i], b[i], a[i]};
    return w;
  endfunction : fw

  function automatic logic [8:0] sa(int s, int k, logic [3:0] f);
    return {1'b0, 2'(s), 2'(k), f};
  endfunction : sa

  assign pw = fw(module_active_flag, module_blocked_flag, step_active_flag, step_blocked_flag,
    pickup_flag, trip_flag);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [8:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d, e);
  endtask : rchk

  // Flag ports and the flags word against the model.
  task automatic cf();
    chk(pw, fw(m_ma, m_mb, m_a, m_b, m_p, m_t));
    rchk(9'h101, fw(m_ma, m_mb, m_a, m_b, m_p, m_t));
  endtask : cf

  // Phase b under the pickup level when lo is not negative, phase c at mid when mid is positive.
  task automatic setc(input int lo, input int mid);
    @(posedge clk_sys);
    current_input_one.ph_a <= 16'(1300 + {$random(seed)} % 700);
    current_input_one.ph_b <= 16'(lo >= 0 ? lo : 1300 + {$random(seed)} % 700);
    current_input_one.ph_c <= 16'(mid > 0 ? mid : 1300 + {$random(seed)} % 700);
    current_input_two <= ucp_cur3_s'({$random(seed), $random(seed)});
  endtask : setc

  task automatic wt(input logic v, output int c);
    c = 0;
    while (trip_flag[0] !== v && c < 200) begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask : wt

  task automatic ev(input int v, input int w);
    @(posedge clk_sys) ev_on <= 14'(v);
    repeat (w) @(posedge clk_sys);
    #1;
  endtask : ev

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // Sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    ev(0, 8);
    cf();
    for (int s = 0; s < 4; s++) begin
      rchk(sa(s, s % 3, UCP_F_SEL), 32'h1);
      rchk(sa(s, s % 3, UCP_F_PK), 32'h0bb8);
      rchk(sa(s, s % 3, UCP_F_REL), 32'h0dac);
      rchk(sa(s, s % 3, UCP_F_TDLY), 32'h3e8);
      rchk(sa(s, 3, UCP_F_EN), 32'h1);
    end
    rchk(9'h100, 32'h0);
    rchk(9'h1ff, 32'h0);
    rchk(9'h104, 32'h0);
    wr(sa(0, 1, UCP_F_PK), 32'h0);
    wr(sa(0, 2, UCP_F_PK), 32'h0);
    wr(sa(0, 0, UCP_F_PK), 32'd1000);
    wr(sa(0, 0, UCP_F_REL), 32'd1200);
    wr(sa(0, 0, UCP_F_TDLY), 32'(TD));
    wr(sa(0, 0, UCP_F_TRD), 32'd4);
    wr(sa(0, 0, UCP_F_PRD), 32'd2);
    wr(9'h103, 32'h3);
    rchk(sa(0, 0, UCP_F_PK), 32'd1000);
    // Trip delay held across an interruption above the pickup level.
    setc(-1, 0);
    setc({$random(seed)} % 1000, 0);
    repeat (2) @(posedge clk_sys);
    #1 m_p = 3'b001;
    cf();
    repeat (9) @(posedge clk_sys);
    setc(-1, 1100);
    repeat (40) @(posedge clk_sys);
    #1 cf();
    setc({$random(seed)} % 1000, 0);
    wt(1'b1, n);
    chk(32'(n >= (TD - 4) * TK - 3 && n <= (TD - 3) * TK + 3), 32'h1);
    m_t = 3'b001;
    cf();
    chk({31'h0, irq}, 32'h1);
    rchk(9'h102, 32'h3);
    wr(9'h103, 32'h0);
    #1 chk({31'h0, irq}, 32'h0);
    wr(9'h103, 32'h3);
    wr(9'h104, 32'h3);
    #1 chk({31'h0, irq}, 32'h0);
    rchk(9'h102, 32'h0);
    // Release, restart of the trip release delay, then full release.
    setc(-1, 0);
    repeat (2) @(posedge clk_sys);
    #1 m_p = 3'b000;
    cf();
    setc({$random(seed)} % 1000, 0);
    repeat (6 * TK) @(posedge clk_sys);
    #1 m_p = 3'b001;
    cf();
    setc(-1, 0);
    wt(1'b0, n);
    chk(32'(n >= 3 * TK - 2 && n <= 4 * TK + 3), 32'h1);
    setc({$random(seed)} % 1000, 0);
    wt(1'b1, n);
    chk(32'(n >= (TD - 1) * TK - 2 && n <= TD * TK + 3), 32'h1);
    // Module and step blocking.
    wr(sa(0, 3, UCP_F_MBLK), 32'd77);
    ev(77, 12);
    m_mb = 1'b1;
    m_p = 3'b000;
    m_t = 3'b000;
    cf();
    ev(0, 12);
    m_mb = 1'b0;
    m_p = 3'b001;
    cf();
    wr(sa(0, 1, UCP_F_SBLK), 32'd55);
    ev(55, 12);
    m_b = 3'b010;
    cf();
    ev(0, 12);
    m_b = 3'b000;
    m_t = 3'b001;
    cf();
    // Module enable.
    wr(sa(0, 3, UCP_F_EN), 32'h0);
    ev(0, 2);
    m_ma = 1'b0;
    m_p = 3'b000;
    m_t = 3'b000;
    cf();
    wr(sa(0, 3, UCP_F_EN), 32'h1);
    ev(0, 2);
    m_ma = 1'b1;
    m_p = 3'b001;
    cf();
    setc(-1, 0);
    ev(0, 2);
    m_p = 3'b000;
    // Every input select code on step two, ending on input one.
    for (int c = 0; c < 3; c++) begin
      wr(sa(0, 2, UCP_F_SEL), 32'((2 * c) % 3));
      #1 m_a[2] = ((2 * c) % 3 == 1);
      cf();
    end
    // Second parameter set with its reset settings.
    wr(9'h100, 32'h1);
    ev(0, 2);
    m_p = 3'b111;
    cf();
    wr(sa(1, 3, UCP_F_EN), 32'h0);
    ev(0, 2);
    m_ma = 1'b0;
    m_p = 3'b000;
    cf();
    final_report();
  end

  // Watchdog: the sequence needs about four hundred cycles, this allows ten thousand.
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
